// ===== core/hem_mailbox_regs.v
// mailbox command registers with host index/data port and controller port
`include "hem_mailbox_regs.vh"
module hem_mailbox_regs (
  input  wire        CLK_SYS_IN,
  input  wire        SRST_IN,
  input  wire        HOST_WR_IN,
  input  wire        HOST_RD_IN,
  input  wire        HOST_PORT_IN,
  input  wire [7:0]  HOST_WDATA_IN,
  output wire [7:0]  HOST_RDATA_OUT,
  input  wire        CTL_WR_IN,
  input  wire        CTL_RD_IN,
  input  wire [11:0] CTL_ADDR_IN,
  input  wire [7:0]  CTL_WDATA_IN,
  output wire [7:0]  CTL_RDATA_OUT,
  input  wire        MAIL_IRQ_ENABLE_IN,
  input  wire [7:1]  SOFT_HOST_IRQ_ENABLES_IN,
  input  wire        OUTBOUND_WRITTEN_ENABLE_IN,
  output wire        CONTROLLER_MAIL_IRQ_OUT,
  output wire        HOST_SERIAL_IRQ_OUT,
  output wire        HOST_SMI_OUT
);

  // ****************************************
  // storage
  // ****************************************
  reg  [7:0] index_ff;
  reg  [7:0] inbound_command_byte_ff;
  reg  [7:0] outbound_command_byte_ff;
  reg  [7:1] soft_host_irq_bits_ff;
  reg        outbound_written_flag_ff;
  reg        controller_mail_irq_ff;
  reg        host_serial_irq_ff;
  reg        host_smi_ff;
  reg  [7:0] host_rdata_ff;
  reg  [7:0] ctl_rdata_ff;

  reg  [7:0] nxt_index;
  reg  [7:0] nxt_inbound;
  reg  [7:0] nxt_outbound;
  wire [7:1] nxt_swi;
  reg        nxt_flag;
  reg        nxt_mail_irq;
  reg  [7:0] nxt_host_rdata;
  reg  [7:0] nxt_ctl_rdata;
  reg        nxt_flag_req;
  reg        nxt_serial;
  reg        nxt_smi;
  wire [7:1] soft_req;

  // ****************************************
  // decode
  // ****************************************
  wire host_data_wr = HOST_WR_IN & (HOST_PORT_IN == `HEM_PORT_DATA);
  wire host_data_rd = HOST_RD_IN & (HOST_PORT_IN == `HEM_PORT_DATA);
  wire host_idx_wr  = HOST_WR_IN & (HOST_PORT_IN == `HEM_PORT_INDEX);
  wire h_in   = index_ff == `HEM_IDX_INBOUND;
  wire h_out  = index_ff == `HEM_IDX_OUTBOUND;
  wire h_src  = index_ff == `HEM_IDX_SOURCE;
  wire c_in   = CTL_ADDR_IN == `HEM_CTL_OFS_INBOUND;
  wire c_out  = CTL_ADDR_IN == `HEM_CTL_OFS_OUTBOUND;
  wire c_src  = CTL_ADDR_IN == `HEM_CTL_OFS_SOURCE;

  // ****************************************
  // access strobes
  // ****************************************
  wire ctl_in_rd   = CTL_RD_IN & c_in;
  wire ctl_in_wr   = CTL_WR_IN & c_in;
  wire ctl_out_wr  = CTL_WR_IN & c_out;
  wire ctl_src_wr  = CTL_WR_IN & c_src;
  wire host_in_wr  = host_data_wr & h_in;
  wire host_out_wr = host_data_wr & h_out;
  wire host_out_rd = host_data_rd & h_out;
  wire host_src_wr = host_data_wr & h_src;

  // ****************************************
  // index register
  // ****************************************
  always @* begin
    nxt_index = index_ff;
    if (host_idx_wr) begin
      nxt_index = HOST_WDATA_IN;
    end
  end

  // ****************************************
  // inbound command byte
  // ****************************************
  always @* begin
    nxt_inbound = inbound_command_byte_ff;
    if (ctl_in_wr) begin
      nxt_inbound = inbound_command_byte_ff & ~CTL_WDATA_IN;
      if (CTL_WDATA_IN == `HEM_BYTE_ONES) begin
        nxt_inbound = `HEM_BYTE_ZERO;
      end
    end
    if (host_in_wr) begin
      nxt_inbound = HOST_WDATA_IN;
    end
  end

  // ****************************************
  // outbound command byte
  // ****************************************
  always @* begin
    nxt_outbound = outbound_command_byte_ff;
    if (ctl_out_wr) begin
      nxt_outbound = CTL_WDATA_IN;
      if (CTL_WDATA_IN == `HEM_BYTE_ONES) begin
        nxt_outbound = `HEM_BYTE_ZERO;
      end
    end
    if (host_out_wr) begin
      nxt_outbound = outbound_command_byte_ff & ~HOST_WDATA_IN;
      if (HOST_WDATA_IN == `HEM_BYTE_ONES) begin
        nxt_outbound = `HEM_BYTE_ZERO;
      end
    end
  end

  // ****************************************
  // controller mail interrupt
  // ****************************************
  always @* begin
    nxt_mail_irq = controller_mail_irq_ff;
    if (ctl_in_rd) begin
      nxt_mail_irq = 1'b0;
    end
    // a host inbound write with MAIL_IRQ_ENABLE_IN set in the same cycle wins
    if (host_in_wr & MAIL_IRQ_ENABLE_IN) begin
      nxt_mail_irq = 1'b1;
    end
  end

  // ****************************************
  // outbound written flag
  // ****************************************
  always @* begin
    nxt_flag = outbound_written_flag_ff;
    if (host_out_rd) begin
      nxt_flag = 1'b0;
    end
    // a controller write in the same cycle wins
    if (ctl_out_wr) begin
      nxt_flag = 1'b1;
    end
  end

  // ****************************************
  // soft interrupt bits, one slice per bit
  // ****************************************
  genvar gi;
  generate
    for (gi = `HEM_SWI_LSB; gi <= `HEM_SWI_MSB; gi = gi + 1) begin : g_swi
      // host clear applied after a same-cycle controller write
      assign nxt_swi[gi]  = (host_src_wr & HOST_WDATA_IN[gi]) ? 1'b0 :
                            ctl_src_wr ? CTL_WDATA_IN[gi] :
                            soft_host_irq_bits_ff[gi];
      assign soft_req[gi] = nxt_swi[gi] &
                            SOFT_HOST_IRQ_ENABLES_IN[gi];
    end
  endgenerate

  // ****************************************
  // host interrupt requests
  // ****************************************
  always @* begin
    nxt_flag_req = nxt_flag & OUTBOUND_WRITTEN_ENABLE_IN;
    nxt_serial   = (|soft_req) | nxt_flag_req;
    nxt_smi      = nxt_flag_req;
  end

  // ****************************************
  // host read data
  // ****************************************
  always @* begin
    nxt_host_rdata = host_rdata_ff;
    if (host_data_rd) begin
      case (index_ff)
        `HEM_IDX_INBOUND: begin
          nxt_host_rdata = inbound_command_byte_ff;
        end
        `HEM_IDX_OUTBOUND: begin
          nxt_host_rdata = outbound_command_byte_ff;
        end
        `HEM_IDX_SOURCE: begin
          nxt_host_rdata = {soft_host_irq_bits_ff,
                            outbound_written_flag_ff};
        end
        default: begin
          nxt_host_rdata = `HEM_BYTE_ZERO;
        end
      endcase
    end else if (HOST_RD_IN) begin
      nxt_host_rdata = index_ff;
    end
  end

  // ****************************************
  // controller read data
  // ****************************************
  always @* begin
    nxt_ctl_rdata = ctl_rdata_ff;
    if (CTL_RD_IN) begin
      case (CTL_ADDR_IN)
        `HEM_CTL_OFS_INBOUND: begin
          nxt_ctl_rdata = inbound_command_byte_ff;
        end
        `HEM_CTL_OFS_OUTBOUND: begin
          nxt_ctl_rdata = outbound_command_byte_ff;
        end
        `HEM_CTL_OFS_SOURCE: begin
          nxt_ctl_rdata = {soft_host_irq_bits_ff, 1'b0};
        end
        default: begin
          nxt_ctl_rdata = `HEM_BYTE_ZERO;
        end
      endcase
    end
  end

  // ****************************************
  // index register flop
  // ****************************************
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      index_ff <= `HEM_BYTE_ZERO;
    end else begin
      index_ff <= nxt_index;
    end
  end

  // ****************************************
  // read data flops
  // ****************************************
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      host_rdata_ff <= `HEM_BYTE_ZERO;
      ctl_rdata_ff  <= `HEM_BYTE_ZERO;
    end else begin
      host_rdata_ff <= nxt_host_rdata;
      ctl_rdata_ff  <= nxt_ctl_rdata;
    end
  end

  // ****************************************
  // mailbox byte flops
  // ****************************************
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      inbound_command_byte_ff  <= `HEM_BYTE_ZERO;
      outbound_command_byte_ff <= `HEM_BYTE_ZERO;
    end else begin
      inbound_command_byte_ff  <= nxt_inbound;
      outbound_command_byte_ff <= nxt_outbound;
    end
  end

  // ****************************************
  // source register flops
  // ****************************************
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      soft_host_irq_bits_ff    <= `HEM_SWI_ZERO;
      outbound_written_flag_ff <= 1'b0;
    end else begin
      soft_host_irq_bits_ff    <= nxt_swi;
      outbound_written_flag_ff <= nxt_flag;
    end
  end

  // ****************************************
  // interrupt flops
  // ****************************************
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      controller_mail_irq_ff <= 1'b0;
      host_serial_irq_ff     <= 1'b0;
      host_smi_ff            <= 1'b0;
    end else begin
      controller_mail_irq_ff <= nxt_mail_irq;
      host_serial_irq_ff     <= nxt_serial;
      host_smi_ff            <= nxt_smi;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign HOST_RDATA_OUT          = host_rdata_ff;
  assign CTL_RDATA_OUT           = ctl_rdata_ff;
  assign CONTROLLER_MAIL_IRQ_OUT = controller_mail_irq_ff;
  assign HOST_SERIAL_IRQ_OUT     = host_serial_irq_ff;
  assign HOST_SMI_OUT            = host_smi_ff;

endmodule

// ===== core/hem_mailbox_regs.vh
// register offsets, indexes and field positions of the mailbox block
`ifndef HEM_MAILBOX_REGS_VH
`define HEM_MAILBOX_REGS_VH
`define HEM_CTL_OFS_INBOUND   12'h0100
`define HEM_CTL_OFS_OUTBOUND  12'h0104
`define HEM_CTL_OFS_SOURCE    12'h0108
`define HEM_IDX_INBOUND       8'h00
`define HEM_IDX_OUTBOUND      8'h01
`define HEM_IDX_SOURCE        8'h02
`define HEM_PORT_INDEX        1'b0
`define HEM_PORT_DATA         1'b1
`define HEM_BYTE_ZERO         8'h00
`define HEM_BYTE_ONES         8'hFF
`define HEM_SWI_ZERO          7'h00
`define HEM_FLAG_BIT          0
`define HEM_SWI_MSB           7
`define HEM_SWI_LSB           1
`endif

// ===== test/hem_mailbox_regs_asserts.sv
// checker on the mailbox register ports
module hem_mailbox_regs_asserts (
  input wire logic        CLK_SYS_IN, SRST_IN, HOST_WR_IN, HOST_RD_IN,
  input wire logic        HOST_PORT_IN, CTL_WR_IN, CTL_RD_IN,
  input wire logic        MAIL_IRQ_ENABLE_IN, OUTBOUND_WRITTEN_ENABLE_IN,
  input wire logic        CONTROLLER_MAIL_IRQ_OUT, HOST_SMI_OUT,
  input wire logic        HOST_SERIAL_IRQ_OUT,
  input wire logic [7:0]  HOST_WDATA_IN, CTL_RDATA_OUT,
  input wire logic [11:0] CTL_ADDR_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  logic [7:0] idx_ff;
  always_ff @(posedge CLK_SYS_IN)
    idx_ff <= SRST_IN ? 8'h00 :
              (HOST_WR_IN && !HOST_PORT_IN) ? HOST_WDATA_IN : idx_ff;
  sequence mail_wr_s;
    HOST_WR_IN && HOST_PORT_IN && idx_ff == 8'h00;
  endsequence
  sequence out_wr_s;
    CTL_WR_IN && CTL_ADDR_IN == 12'h0104;
  endsequence
  mail_irq_set_a: assert property (mail_wr_s ##0 MAIL_IRQ_ENABLE_IN
    |=> CONTROLLER_MAIL_IRQ_OUT) else $error("mail irq not set");
  mail_irq_clr_a: assert property (CTL_RD_IN
    && CTL_ADDR_IN == 12'h0100 && !HOST_WR_IN |=> !CONTROLLER_MAIL_IRQ_OUT)
    else $error("mail irq kept");
  mail_irq_hold_a: assert property (CONTROLLER_MAIL_IRQ_OUT
    && !CTL_RD_IN |=> CONTROLLER_MAIL_IRQ_OUT) else $error("mail irq lost");
  flag_irq_a: assert property (out_wr_s
    ##0 OUTBOUND_WRITTEN_ENABLE_IN |=> HOST_SMI_OUT && HOST_SERIAL_IRQ_OUT)
    else $error("flag irq missing");
  smi_mask_a: assert property (!OUTBOUND_WRITTEN_ENABLE_IN
    |=> !HOST_SMI_OUT) else $error("smi unmasked");
  smi_release_a: assert property (HOST_RD_IN && HOST_PORT_IN
    && idx_ff == 8'h01 && !CTL_WR_IN |=> !HOST_SMI_OUT) else $error("smi kept");
  src_bit0_a: assert property (CTL_RD_IN && CTL_ADDR_IN == 12'h0108
    |=> !CTL_RDATA_OUT[0]) else $error("flag visible");
  reset_quiet_a: assert property (disable iff (1'b0) SRST_IN |=>
    !CONTROLLER_MAIL_IRQ_OUT && !HOST_SMI_OUT && !HOST_SERIAL_IRQ_OUT)
    else $error("irq after reset");
endmodule
bind hem_mailbox_regs hem_mailbox_regs_asserts chk (.*);

// ===== test/hem_host_model.sv
// host cpu model on the index/data port
module hem_host_model (
  input  wire logic  clk,
  output logic       wr, rd, port,
  output logic [7:0] wd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {wr, rd, port, wd} = 11'h000;
  // one strobe cycle, data inverted once released
  task automatic acc(input logic w, p, input logic [7:0] d);
    @(negedge clk) {wr, rd, port, wd} = {w, !w, p, d};
    @(negedge clk) {wr, rd, wd} = {2'b00, ~d};
  endtask
  task automatic sel(input logic [7:0] i);
    acc(1'b1, 1'b0, i);
  endtask
endmodule

// ===== test/hem_mailbox_regs_tb.sv
// self-checking bench of the mailbox registers
module hem_mailbox_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, cwr = 0, crd = 0, men = 1, wen = 1;
  logic [11:0] ca = 12'h000;
  logic [7:0] cd = 8'h00, hw, hd, cr;
  logic [7:1] sen = 7'h02;
  logic hwr, hrd, hp, mi, si, smi;
  int error_cnt = 0, checks = 0, cyc = 0;
  logic [27:0] rows [4] = '{28'h104_5A5A, 28'h104_FF00, 28'h108_FFFE,
    28'h10C_1100};
  always #2.5 clk = ~clk;
  hem_host_model host (.clk(clk), .wr(hwr), .rd(hrd), .port(hp), .wd(hw));
  hem_mailbox_regs dut (.CLK_SYS_IN(clk), .SRST_IN(rst), .HOST_WR_IN(hwr),
    .HOST_RD_IN(hrd), .HOST_PORT_IN(hp), .HOST_WDATA_IN(hw),
    .HOST_RDATA_OUT(hd), .CTL_WR_IN(cwr), .CTL_RD_IN(crd), .CTL_ADDR_IN(ca),
    .CTL_WDATA_IN(cd), .CTL_RDATA_OUT(cr), .MAIL_IRQ_ENABLE_IN(men),
    .SOFT_HOST_IRQ_ENABLES_IN(sen), .OUTBOUND_WRITTEN_ENABLE_IN(wen),
    .CONTROLLER_MAIL_IRQ_OUT(mi), .HOST_SERIAL_IRQ_OUT(si), .HOST_SMI_OUT(smi));
  task automatic chk(input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cac(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(negedge clk) {cwr, crd, ca, cd} = {w, !w, a, d};
    @(negedge clk) {cwr, crd, cd} = {2'b00, ~d};
  endtask
  task automatic end_of_test;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 1000) begin
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    chk({mi, si, smi}, 8'h00);
    foreach (rows[i]) begin
      cac(1'b1, rows[i][27:16], rows[i][15:8]);
      cac(1'b0, rows[i][27:16], 8'h00);
      chk(cr, rows[i][7:0]);
    end
    chk({si, smi}, 8'h03);
    host.sel(8'h02);
    host.acc(1'b0, 1'b1, 8'h00);
    chk(hd, 8'hFF);
    host.acc(1'b1, 1'b1, 8'hFE);
    host.acc(1'b0, 1'b1, 8'h00);
    chk(hd, 8'h01);
    cac(1'b1, 12'h104, 8'h5A);
    host.sel(8'h01);
    host.acc(1'b0, 1'b1, 8'h00);
    chk(hd, 8'h5A);
    chk({si, smi}, 8'h00);
    host.acc(1'b1, 1'b1, 8'h0F);
    cac(1'b0, 12'h104, 8'h00);
    chk(cr, 8'h50);
    cac(1'b1, 12'h108, 8'h04);
    chk({si, smi}, 8'h02);
    sen = 7'h00;
    @(negedge clk) chk(si, 8'h00);
    host.sel(8'h00);
    host.acc(1'b1, 1'b1, 8'hF3);
    chk(mi, 8'h01);
    cac(1'b1, 12'h100, 8'h03);
    cac(1'b0, 12'h100, 8'h00);
    chk({cr, mi}, 9'h1E0);
    cac(1'b1, 12'h100, 8'hFF);
    host.acc(1'b0, 1'b1, 8'h00);
    chk(hd, 8'h00);
    men = 0;
    host.acc(1'b1, 1'b1, 8'h12);
    chk(mi, 8'h00);
    wen = 0;
    cac(1'b1, 12'h104, 8'h33);
    chk({si, smi}, 8'h00);
    wen = 1;
    @(negedge clk) chk({si, smi}, 8'h03);
    rst = 1;
    @(negedge clk) rst = 0;
    chk({mi, si, smi}, 8'h00);
    chk({hd, cr}, 16'h0000);
    host.sel(8'h02);
    host.acc(1'b0, 1'b1, 8'h00);
    chk(hd, 8'h00);
    end_of_test;
  end
endmodule
